/* hdl/clkgen_pkg.sv */
// Constants, register map and carrier types of the clock source generator.
// Assumes one 50 MHz system clock; every oscillator arrives as a one-cycle tick.
// Contract
// - Main oscillator runs after reset, not CPU source
// - Stop mode disconnects main and sub feedback resistors
// - main_fb_resistor_off set leaves feedback resistor open
// - PLL held stopped after reset until enabled
// - PLL clock is main divided, then multiplied
// - fast_osc_clock comes straight from fast oscillator
// - fast_div_clock divides fast oscillator, stopped after reset
// - Main loss with fast selected switches to fast_div_clock
// - Main loss with slow selected starts slow oscillator
// - onchip_clock_select forces slow_osc_off to zero
// - Sub oscillator stopped, resistor open after reset
// - CPU divides by 1-16; sub clock undivided
// - Reset CPU clock is slow oscillator by eight
// - Stop mode, or main stopped with onchip_clock_select clear, forces div8_force
// - Fast divider register writable only when unlocked
// - clock_lock blocks main stop, sub select, detect enable and PLL writes, cannot clear
package clkgen_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    localparam logic [3:0] OFS_OSC_CTRL0  = 4'h0;
    localparam logic [3:0] OFS_OSC_CTRL1  = 4'h1;
    localparam logic [3:0] OFS_DETECT     = 4'h2;
    localparam logic [3:0] OFS_PLL        = 4'h3;
    localparam logic [3:0] OFS_FAST_OSC   = 4'h4;
    localparam logic [3:0] OFS_FAST_DIV   = 4'h5;
    localparam logic [3:0] OFS_UNLOCK     = 4'h6;
    localparam logic [3:0] OFS_LOCK       = 4'h7;
    localparam logic [3:0] OFS_STATUS     = 4'h8;

    // Control 0
    localparam int B_MAIN_STOP  = 0;
    localparam int B_SUB_EN     = 1;
    localparam int B_SUB_DRIVE  = 2;
    localparam int B_DIV8       = 3;
    localparam int B_SUB_SEL    = 4;
    localparam int B_MAIN_DRIVE = 5;
    // Control 1
    localparam int B_FB_OFF     = 0;
    localparam int B_SLOW_OFF   = 1;
    localparam int B_CPU_DIV    = 2;
    // Detect
    localparam int B_DET_EN     = 0;
    localparam int B_ONCHIP_SEL = 1;
    localparam int B_MAIN_DEAD  = 3;
    localparam int B_DET_ACT    = 7;
    // PLL
    localparam int B_PLL_MULT   = 0;
    localparam int B_PLL_REF    = 4;
    localparam int B_PLL_ON     = 7;
    // Fast oscillator, unlock, lock
    localparam int B_FAST_ON    = 0;
    localparam int B_FAST_SEL   = 1;
    localparam int B_UNLOCK     = 0;
    localparam int B_LOCK       = 1;
    // Status
    localparam int B_ACT_SRC    = 0;
    localparam int B_ACT_SHIFT  = 4;

    localparam logic [7:0] RST_OSC_CTRL0 = 8'h08;
    localparam logic [7:0] RST_OSC_CTRL1 = 8'h00;
    localparam logic [7:0] RST_DETECT    = 8'h02;
    localparam logic [7:0] RST_PLL       = 8'h12;
    localparam logic [7:0] RST_FAST_OSC  = 8'h00;
    localparam logic [2:0] RST_FAST_DIV  = 3'h0;

    localparam logic [2:0] SHIFT_DIV8    = 3'h3;
    localparam logic [2:0] SHIFT_DIV16   = 3'h4;

    typedef enum logic [2:0] {SRC_MAIN, SRC_PLL, SRC_FAST, SRC_SLOW, SRC_SUB} src_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } reg_req_t;

    typedef struct packed {
        logic main;
        logic pll;
        logic fast;
        logic slow;
        logic sub;
    } osc_ticks_t;

    typedef struct packed {
        logic       main_run;
        logic       main_fb_connect;
        logic       main_drive_high;
        logic       pll_run;
        logic [1:0] pll_ref_div;
        logic [2:0] pll_mult;
        logic       fast_run;
        logic       slow_run;
        logic       sub_run;
        logic       sub_fb_connect;
        logic       sub_drive_high;
    } osc_ctrl_t;
endpackage : clkgen_pkg

/* hdl/tick_divider.sv */
// Divides a tick stream by ratio + 1 and emits one registered tick per period.
// Assumes tick is a one-cycle enable in the clk_sys domain.
module tick_divider #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         tick,
    input  wire logic [W-1:0] ratio,
    output logic              div_tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } div_state_t;

    div_state_t st_ff;
    div_state_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (tick)
        begin
            // Ratio is compared on every tick, so lowering it to or below the count ends the period at the next tick
            if (st_ff.cnt >= ratio)
            begin
                nxt_st.cnt = '0;
                nxt_st.pulse = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign div_tick = st_ff.pulse;
endmodule : tick_divider

/* hdl/cpu_clock_switch.sv */
// Picks the CPU clock source and divides it by a power of two.
// Assumes source ticks are one-cycle enables; main_dead flags a lost main oscillator.
module cpu_clock_switch (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire clkgen_pkg::osc_ticks_t ticks,
    input  wire clkgen_pkg::src_t     req_src,
    input  wire logic [2:0]           req_shift,
    input  wire logic                 main_dead,
    output logic                      cpu_clk_en,
    output clkgen_pkg::src_t          act_src,
    output logic [2:0]                act_shift
);
    typedef struct packed {
        clkgen_pkg::src_t src;
        logic [2:0]       shift;
        logic [3:0]       cnt;
        logic             pulse;
    } sw_state_t;

    sw_state_t  st_ff;
    sw_state_t  nxt_st;
    logic       tick;
    logic       dead;
    logic [3:0] limit;

    always_comb
    begin
        unique case (st_ff.src)
            clkgen_pkg::SRC_MAIN: tick = ticks.main;
            clkgen_pkg::SRC_PLL:  tick = ticks.pll;
            clkgen_pkg::SRC_FAST: tick = ticks.fast;
            clkgen_pkg::SRC_SLOW: tick = ticks.slow;
            clkgen_pkg::SRC_SUB:  tick = ticks.sub;
            default:              tick = 1'b0;
        endcase
        dead = main_dead && (st_ff.src == clkgen_pkg::SRC_MAIN
                             || st_ff.src == clkgen_pkg::SRC_PLL);
        limit = 4'((5'h01 << st_ff.shift) - 5'h01);
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (dead)
        begin
            // A dead source never ends its period, so the partial period is dropped
            nxt_st.src = req_src;
            nxt_st.shift = req_shift;
            nxt_st.cnt = 4'h0;
        end
        else if (tick)
        begin
            if (st_ff.cnt == limit)
            begin
                nxt_st.pulse = 1'b1;
                nxt_st.cnt = 4'h0;
                nxt_st.src = req_src;
                nxt_st.shift = req_shift;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 4'h1;
            end
        end
        else if (st_ff.cnt == 4'h0)
        begin
            nxt_st.src = req_src;
            nxt_st.shift = req_shift;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff.src <= clkgen_pkg::SRC_SLOW;
            st_ff.shift <= clkgen_pkg::SHIFT_DIV8;
            st_ff.cnt <= 4'h0;
            st_ff.pulse <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cpu_clk_en = st_ff.pulse;
    assign act_src = st_ff.src;
    assign act_shift = st_ff.shift;
endmodule : cpu_clock_switch

/* hdl/clock_source_generator.sv */
// Clock source generator: oscillator controls, PLL settings, fallback and CPU clock.
// Assumes oscillator ticks, stop mode and main-loss level are synchronous to clk_sys.
module clock_source_generator #(
    parameter int FAST_DIV_W = 3
) (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire clkgen_pkg::reg_req_t   reg_req,
    output logic [clkgen_pkg::DATA_W-1:0] reg_rdata,
    input  wire clkgen_pkg::osc_ticks_t osc_ticks,
    input  wire logic                   stop_mode,
    input  wire logic                   main_stopped,
    output clkgen_pkg::osc_ctrl_t       osc_ctrl,
    output clkgen_pkg::osc_ticks_t      src_clk_en,
    output logic                        fast_osc_clock_en,
    output logic                        cpu_clk_en
);
    typedef struct packed {
        logic                  main_osc_stop;
        logic                  main_fb_resistor_off;
        logic                  main_drive_high;
        logic                  sub_osc_enable;
        logic                  sub_drive_high;
        logic                  div8_force;
        logic                  sub_select;
        logic                  slow_osc_off;
        logic [1:0]            cpu_div_select;
        logic                  osc_detect_enable;
        logic                  onchip_clock_select;
        logic                  detect_action_select;
        logic [2:0]            pll_mult;
        logic [1:0]            pll_ref_div;
        logic                  pll_on;
        logic                  fast_osc_on;
        logic                  onchip_osc_select;
        logic [FAST_DIV_W-1:0] fast_div;
        logic                  clock_write_unlock;
        logic                  clock_lock;
        logic [7:0]            rdata;
    } ctl_state_t;

    ctl_state_t       st_ff;
    ctl_state_t       nxt_st;
    clkgen_pkg::src_t req_src;
    clkgen_pkg::src_t act_src;
    logic [2:0]       req_shift;
    logic [2:0]       act_shift;
    logic             fast_div_tick;
    logic             wr;
    logic [7:0]       wd;
    clkgen_pkg::osc_ticks_t gated;

    assign wr = reg_req.we;
    assign wd = reg_req.wdata;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata = 8'h00;
        if (wr)
        begin
            unique case (reg_req.addr)
                clkgen_pkg::OFS_OSC_CTRL0:
                begin
                    if (!st_ff.clock_lock)
                    begin
                        nxt_st.main_osc_stop = wd[clkgen_pkg::B_MAIN_STOP];
                        nxt_st.sub_select = wd[clkgen_pkg::B_SUB_SEL];
                    end
                    nxt_st.sub_osc_enable = wd[clkgen_pkg::B_SUB_EN];
                    nxt_st.sub_drive_high = wd[clkgen_pkg::B_SUB_DRIVE];
                    nxt_st.div8_force = wd[clkgen_pkg::B_DIV8];
                    nxt_st.main_drive_high = wd[clkgen_pkg::B_MAIN_DRIVE];
                end
                clkgen_pkg::OFS_OSC_CTRL1:
                begin
                    nxt_st.main_fb_resistor_off = wd[clkgen_pkg::B_FB_OFF];
                    nxt_st.slow_osc_off = wd[clkgen_pkg::B_SLOW_OFF];
                    nxt_st.cpu_div_select = wd[clkgen_pkg::B_CPU_DIV +: 2];
                end
                clkgen_pkg::OFS_DETECT:
                begin
                    if (!st_ff.clock_lock)
                        nxt_st.osc_detect_enable = wd[clkgen_pkg::B_DET_EN];
                    nxt_st.onchip_clock_select = wd[clkgen_pkg::B_ONCHIP_SEL];
                    nxt_st.detect_action_select = wd[clkgen_pkg::B_DET_ACT];
                end
                clkgen_pkg::OFS_PLL:
                begin
                    if (!st_ff.clock_lock)
                    begin
                        nxt_st.pll_mult = wd[clkgen_pkg::B_PLL_MULT +: 3];
                        nxt_st.pll_ref_div = wd[clkgen_pkg::B_PLL_REF +: 2];
                        nxt_st.pll_on = wd[clkgen_pkg::B_PLL_ON];
                    end
                end
                clkgen_pkg::OFS_FAST_OSC:
                begin
                    nxt_st.fast_osc_on = wd[clkgen_pkg::B_FAST_ON];
                    nxt_st.onchip_osc_select = wd[clkgen_pkg::B_FAST_SEL];
                end
                clkgen_pkg::OFS_FAST_DIV:
                begin
                    if (st_ff.clock_write_unlock)
                        nxt_st.fast_div = wd[FAST_DIV_W-1:0];
                end
                clkgen_pkg::OFS_UNLOCK:
                    nxt_st.clock_write_unlock = wd[clkgen_pkg::B_UNLOCK];
                clkgen_pkg::OFS_LOCK:
                    nxt_st.clock_lock = st_ff.clock_lock | wd[clkgen_pkg::B_LOCK];
                default:
                    nxt_st.clock_lock = st_ff.clock_lock;
            endcase
        end
        // Hardware sets are applied after the write so they win over a clearing write
        if (main_stopped && st_ff.osc_detect_enable && st_ff.detect_action_select)
            nxt_st.onchip_clock_select = 1'b1;
        if (nxt_st.onchip_clock_select)
            nxt_st.slow_osc_off = 1'b0;
        if (stop_mode || (!st_ff.onchip_clock_select && st_ff.main_osc_stop))
            nxt_st.div8_force = 1'b1;
        if (reg_req.re)
        begin
            unique case (reg_req.addr)
                clkgen_pkg::OFS_OSC_CTRL0:
                    nxt_st.rdata = {2'b00, st_ff.main_drive_high, st_ff.sub_select,
                                    st_ff.div8_force, st_ff.sub_drive_high,
                                    st_ff.sub_osc_enable, st_ff.main_osc_stop};
                clkgen_pkg::OFS_OSC_CTRL1:
                    nxt_st.rdata = {4'h0, st_ff.cpu_div_select, st_ff.slow_osc_off,
                                    st_ff.main_fb_resistor_off};
                clkgen_pkg::OFS_DETECT:
                    nxt_st.rdata = {st_ff.detect_action_select, 3'b000, main_stopped,
                                    1'b0, st_ff.onchip_clock_select,
                                    st_ff.osc_detect_enable};
                clkgen_pkg::OFS_PLL:
                    nxt_st.rdata = {st_ff.pll_on, 1'b0, st_ff.pll_ref_div, 1'b0,
                                    st_ff.pll_mult};
                clkgen_pkg::OFS_FAST_OSC:
                    nxt_st.rdata = {6'h00, st_ff.onchip_osc_select, st_ff.fast_osc_on};
                clkgen_pkg::OFS_FAST_DIV:
                    nxt_st.rdata = 8'(st_ff.fast_div);
                clkgen_pkg::OFS_UNLOCK:
                    nxt_st.rdata = {7'h00, st_ff.clock_write_unlock};
                clkgen_pkg::OFS_LOCK:
                    nxt_st.rdata = {6'h00, st_ff.clock_lock, 1'b0};
                clkgen_pkg::OFS_STATUS:
                    nxt_st.rdata = {1'b0, act_shift, 1'b0, act_src};
                default:
                    nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff <= '0;
            st_ff.main_osc_stop <= clkgen_pkg::RST_OSC_CTRL0[clkgen_pkg::B_MAIN_STOP];
            st_ff.sub_osc_enable <= clkgen_pkg::RST_OSC_CTRL0[clkgen_pkg::B_SUB_EN];
            st_ff.div8_force <= clkgen_pkg::RST_OSC_CTRL0[clkgen_pkg::B_DIV8];
            st_ff.slow_osc_off <= clkgen_pkg::RST_OSC_CTRL1[clkgen_pkg::B_SLOW_OFF];
            st_ff.onchip_clock_select <= clkgen_pkg::RST_DETECT[clkgen_pkg::B_ONCHIP_SEL];
            st_ff.pll_mult <= clkgen_pkg::RST_PLL[clkgen_pkg::B_PLL_MULT +: 3];
            st_ff.pll_ref_div <= clkgen_pkg::RST_PLL[clkgen_pkg::B_PLL_REF +: 2];
            st_ff.pll_on <= clkgen_pkg::RST_PLL[clkgen_pkg::B_PLL_ON];
            st_ff.fast_osc_on <= clkgen_pkg::RST_FAST_OSC[clkgen_pkg::B_FAST_ON];
            st_ff.fast_div <= FAST_DIV_W'(clkgen_pkg::RST_FAST_DIV);
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Requested source and ratio; the switch applies them at a period boundary
    always_comb
    begin
        if (st_ff.sub_select)
            req_src = clkgen_pkg::SRC_SUB;
        else if (st_ff.onchip_clock_select)
            req_src = st_ff.onchip_osc_select ? clkgen_pkg::SRC_FAST : clkgen_pkg::SRC_SLOW;
        else
            req_src = st_ff.pll_on ? clkgen_pkg::SRC_PLL : clkgen_pkg::SRC_MAIN;
        if (st_ff.sub_select)
            req_shift = 3'h0;
        else if (st_ff.div8_force)
            req_shift = clkgen_pkg::SHIFT_DIV8;
        else if (st_ff.cpu_div_select == 2'h3)
            req_shift = clkgen_pkg::SHIFT_DIV16;
        else
            req_shift = {1'b0, st_ff.cpu_div_select};
    end

    // Ticks pass only while their oscillator is enabled
    always_comb
    begin
        gated.main = osc_ticks.main && !st_ff.main_osc_stop;
        gated.pll = osc_ticks.pll && st_ff.pll_on && !main_stopped;
        gated.fast = fast_div_tick;
        gated.slow = osc_ticks.slow && !st_ff.slow_osc_off;
        gated.sub = osc_ticks.sub && st_ff.sub_osc_enable;
    end

    tick_divider #(
        .W (FAST_DIV_W)
    ) u_fast_div (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .tick     (osc_ticks.fast && st_ff.fast_osc_on),
        .ratio    (st_ff.fast_div),
        .div_tick (fast_div_tick)
    );

    cpu_clock_switch u_cpu_sw (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .ticks      (gated),
        .req_src    (req_src),
        .req_shift  (req_shift),
        .main_dead  (main_stopped),
        .cpu_clk_en (cpu_clk_en),
        .act_src    (act_src),
        .act_shift  (act_shift)
    );

    assign src_clk_en = gated;
    assign fast_osc_clock_en = osc_ticks.fast && st_ff.fast_osc_on;
    assign reg_rdata = st_ff.rdata;

    // Analog macro controls; the PLL macro does the division and multiplication itself
    always_comb
    begin
        osc_ctrl.main_run = !st_ff.main_osc_stop;
        osc_ctrl.main_fb_connect = !st_ff.main_fb_resistor_off && !stop_mode;
        osc_ctrl.main_drive_high = st_ff.main_drive_high;
        osc_ctrl.pll_run = st_ff.pll_on;
        osc_ctrl.pll_ref_div = st_ff.pll_ref_div;
        osc_ctrl.pll_mult = st_ff.pll_mult;
        osc_ctrl.fast_run = st_ff.fast_osc_on;
        osc_ctrl.slow_run = !st_ff.slow_osc_off;
        osc_ctrl.sub_run = st_ff.sub_osc_enable;
        osc_ctrl.sub_fb_connect = st_ff.sub_osc_enable && !stop_mode;
        osc_ctrl.sub_drive_high = st_ff.sub_drive_high;
    end
endmodule : clock_source_generator

/* sim/clkgen_checker_asserts.sv */
// Checker for the clock source generator, bound to its top module.
// Assumes one clock domain and the register map of clkgen_pkg.
module clkgen_checker #(
    parameter int FAST_DIV_W = 3
) (
    input wire logic                   clk_sys,
    input wire logic                   nrst,
    input wire clkgen_pkg::reg_req_t   reg_req,
    input wire logic [7:0]             reg_rdata,
    input wire clkgen_pkg::osc_ticks_t osc_ticks,
    input wire logic                   stop_mode,
    input wire logic                   main_stopped,
    input wire clkgen_pkg::osc_ctrl_t  osc_ctrl,
    input wire clkgen_pkg::osc_ticks_t src_clk_en,
    input wire logic                   fast_osc_clock_en,
    input wire logic                   cpu_clk_en
);
    logic locked_ff;
    // Sticky copy of the lock bit; only reset clears it
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            locked_ff <= 1'b0;
        else if (reg_req.we && reg_req.addr == clkgen_pkg::OFS_LOCK && reg_req.wdata[1])
            locked_ff <= 1'b1;
    end
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_stop_ctrl0_read;
        stop_mode ##1 stop_mode && reg_req.re && reg_req.addr == clkgen_pkg::OFS_OSC_CTRL0;
    endsequence
    sequence s_pll_write;
        reg_req.we && reg_req.addr == clkgen_pkg::OFS_PLL;
    endsequence
    AST_FB_STOP: assert property (stop_mode |-> !osc_ctrl.main_fb_connect &&
        !osc_ctrl.sub_fb_connect) else $error("feedback resistor on in stop mode");
    AST_FB_OFF: assert property (reg_req.we && reg_req.addr == 4'h1 &&
        reg_req.wdata[0] |=> !osc_ctrl.main_fb_connect) else $error("feedback not opened");
    AST_RST_STATE: assert property ($rose(nrst) |-> osc_ctrl.main_run &&
        !osc_ctrl.pll_run && !osc_ctrl.sub_run && !osc_ctrl.sub_fb_connect)
        else $error("oscillator state after reset wrong");
    AST_FAST_CLK: assert property (fast_osc_clock_en == (osc_ticks.fast &&
        osc_ctrl.fast_run)) else $error("fast clock not the gated oscillator");
    AST_CPU_CAUSE: assert property (cpu_clk_en |-> $past(src_clk_en) != '0)
        else $error("cpu clock without a source tick");
    AST_RST_CPU: assert property ($rose(nrst) |-> !cpu_clk_en [*8])
        else $error("cpu clock too early after reset");
    AST_DIV8_STOP: assert property (s_stop_ctrl0_read |=> reg_rdata[3])
        else $error("divide by eight not forced in stop mode");
    AST_PLL_LOCKED: assert property (locked_ff ##0 s_pll_write |=>
        $stable({osc_ctrl.pll_run, osc_ctrl.pll_ref_div, osc_ctrl.pll_mult}))
        else $error("pll changed while locked");
    AST_PLL_WRITE: assert property (!locked_ff ##0 s_pll_write |=>
        {osc_ctrl.pll_ref_div, osc_ctrl.pll_mult} == {$past(reg_req.wdata[5:4]),
        $past(reg_req.wdata[2:0])}) else $error("pll ratio not taken");
endmodule : clkgen_checker

bind clock_source_generator clkgen_checker #(.FAST_DIV_W(FAST_DIV_W)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .osc_ticks(osc_ticks), .stop_mode(stop_mode), .main_stopped(main_stopped),
    .osc_ctrl(osc_ctrl), .src_clk_en(src_clk_en), .fast_osc_clock_en(fast_osc_clock_en),
    .cpu_clk_en(cpu_clk_en));

/* sim/clock_source_generator_bench.sv */
// Self-checking bench for the clock source generator.
// Assumes the register map, reset values and divide codes of clkgen_pkg.
module clock_source_generator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic                   clk_sys = 1'b0;
    logic                   nrst = 1'b0;
    clkgen_pkg::reg_req_t   reg_req = '0;
    logic [7:0]             reg_rdata;
    clkgen_pkg::osc_ticks_t osc_ticks = '0;
    logic [4:0]             tick_en = 5'h02;
    logic                   stop_mode = 1'b0;
    logic                   main_stopped = 1'b0;
    clkgen_pkg::osc_ctrl_t  osc_ctrl;
    clkgen_pkg::osc_ticks_t src_clk_en;
    logic                   fast_osc_clock_en;
    logic                   cpu_clk_en;
    logic [15:0]            lfsr = 16'h8b84;
    logic [2:0]             cnt_bit = 3'h1;
    logic [7:0]             cnt = '0;
    logic [7:0]             period = '0;
    int                     pulses = 0;
    int                     cycles = 0;
    int                     mismatches = 0;
    int                     check_count = 0;
    logic [7:0] rst_val [0:8] = '{8'h08, 8'h00, 8'h02, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h33};
    logic [7:0] ratio [0:3] = '{8'h01, 8'h02, 8'h04, 8'h10};
    logic [7:0] stat [0:3] = '{8'h00, 8'h10, 8'h20, 8'h40};
    wire logic [4:0]        tick_bits = osc_ticks;

    clock_source_generator #(.FAST_DIV_W(3)) dut (
        .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .osc_ticks(osc_ticks), .stop_mode(stop_mode), .main_stopped(main_stopped),
        .osc_ctrl(osc_ctrl), .src_clk_en(src_clk_en),
        .fast_osc_clock_en(fast_osc_clock_en), .cpu_clk_en(cpu_clk_en));

    always #10 clk_sys = ~clk_sys;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr_next

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_sys);
        reg_req.we <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk_sys);
        reg_req.re <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // Skips the period in flight, which may mix two settings
    task automatic period_is(input logic [2:0] b, input logic [7:0] exp);
        int n;
        cnt_bit = b;
        n = pulses;
        while (pulses < n + 3)
            @(posedge clk_sys);
        #1;
        chk(period, exp);
    endtask : period_is

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        lfsr <= lfsr_next(lfsr);
        osc_ticks <= tick_en & lfsr[4:0];
        cnt <= (cpu_clk_en ? 8'h00 : cnt) + {7'h00, tick_bits[cnt_bit]};
        if (cpu_clk_en)
        begin
            period <= cnt;
            pulses <= pulses + 1;
        end
        if (cycles == LIMIT)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        chk({2'b00, osc_ctrl.main_run, osc_ctrl.pll_run, osc_ctrl.sub_run,
            osc_ctrl.sub_fb_connect, osc_ctrl.fast_run, osc_ctrl.slow_run}, 8'h21);
        for (int i = 0; i < 9; i++)
            rd(4'(i), rst_val[i]);
        rd(4'hf, 8'h00);
        period_is(3'h1, 8'h08);
        $display("test reset finished");
        wr(4'h1, 8'h01);
        chk({7'h0, osc_ctrl.main_fb_connect}, 8'h00);
        wr(4'h1, 8'h02);
        chk({7'h0, osc_ctrl.slow_run}, 8'h01);
        rd(4'h1, 8'h00);
        wr(4'h0, 8'h00);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({6'h0, osc_ctrl.main_fb_connect, osc_ctrl.sub_fb_connect}, 8'h00);
        rd(4'h0, 8'h08);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wr(4'h4, 8'h01);
        tick_en <= 5'h06;
        repeat (8)
        begin
            @(posedge clk_sys);
            #1;
            chk({7'h0, fast_osc_clock_en}, {7'h0, osc_ticks.fast});
        end
        wr(4'h5, 8'h03);
        rd(4'h5, 8'h00);
        wr(4'h6, 8'h01);
        wr(4'h5, 8'h03);
        rd(4'h5, 8'h03);
        $display("test onchip finished");
        tick_en <= 5'h1f;
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(4'h1, {4'h0, 2'(k), 2'b00});
            period_is(3'h4, ratio[k]);
            rd(4'h8, stat[k]);
        end
        wr(4'h0, 8'h08);
        period_is(3'h4, 8'h08);
        wr(4'h0, 8'h16);
        chk({5'h0, osc_ctrl.sub_run, osc_ctrl.sub_fb_connect,
            osc_ctrl.sub_drive_high}, 8'h07);
        period_is(3'h0, 8'h01);
        rd(4'h8, 8'h04);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h09);
        wr(4'h0, 8'h21);
        chk({7'h0, osc_ctrl.main_drive_high}, 8'h01);
        wr(4'h0, 8'h20);
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        wr(4'h3, 8'h24);
        chk({2'b00, osc_ctrl.pll_run, osc_ctrl.pll_ref_div, osc_ctrl.pll_mult}, 8'h14);
        $display("test divide finished");
        wr(4'h4, 8'h03);
        wr(4'h2, 8'h81);
        @(posedge clk_sys);
        main_stopped <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(4'h2, 8'h8b);
        rd(4'h8, 8'h02);
        @(posedge clk_sys);
        main_stopped <= 1'b0;
        wr(4'h2, 8'h81);
        wr(4'h4, 8'h01);
        wr(4'h1, 8'h02);
        chk({7'h0, osc_ctrl.slow_run}, 8'h00);
        repeat (20) @(posedge clk_sys);
        rd(4'h8, 8'h00);
        @(posedge clk_sys);
        main_stopped <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h0, osc_ctrl.slow_run}, 8'h01);
        rd(4'h8, 8'h03);
        $display("test fallback finished");
        wr(4'h7, 8'h02);
        wr(4'h3, 8'ha4);
        rd(4'h3, 8'h24);
        wr(4'h7, 8'h00);
        rd(4'h7, 8'h02);
        $display("test lock finished");
        report_and_stop();
    end
endmodule : clock_source_generator_bench
